// >>> hdl/ppa_port.sv
/*
 Parallel port controller: register file on an Avalon-MM slave, master
 cycles with programmable wait states, target address with chip-select
 option, pad ownership and slave buffer status.
 Assumes host strobes and DATA_IN are synchronous to CORE_CLK.
*/
// Implementation choices: register access over Avalon-MM and the placing of the registers.
// Summary of operation
// - write hold after strobe lasts hold code plus one cycles
// - read hold after strobe lasts exactly hold code cycles
// - width code zero forces setup one, hold one on writes, zero on reads
// - auto step never touches bit 14 while it serves as chip select
// - chip-select function 10: bit 14 of target drives the chip select
// - chip-select function 00 or 01: bit 14 is address bit 14
// - target holds 11 address bits; bits 13-11 and above 14 read zero
// - high pad enable gives pad 14 to the port, else general I/O
// - pad enables 10 to 2 give those pads to the address output
// - pad enables 1 and 0 give those pads to address or latch strobes
// - mux select field picks address bits or latch strobes on pads 1-0
// - buffer flags carry meaning only in slave modes
// - in_all_full set only when every writable input slot is full
// - host write to full slot sets in_overrun_flag until software clears
// - in_slot_full sets on host data, clears on software read of slot
// - out_all_empty set when all readable output slots empty, resets 1
// - host read of empty slot sets out_underrun_flag until cleared
// - out_slot_empty resets 1, clears on software write, sets when sent
// - mode field: legacy slave, addressable slave, two master styles
// - chip-select function 10 chip select, 00/01 address, 11 reserved
`timescale 1ns/1ps
module ppa_port (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        HOST_CS,
  input  wire logic        HOST_RD,
  input  wire logic        HOST_WR,
  input  wire logic [1:0]  HOST_ADDR,
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic             DATA_OE,
  output logic             RD_STROBE,
  output logic             WR_STROBE,
  output logic      [14:0] PAD_OUT,
  output logic      [14:0] PAD_OWN
);
  localparam int W = ppa_pkg::BYTE_W;

  logic [31:0]                ctrl_q;
  logic [31:0]                target_q;
  logic [31:0]                pins_q;
  logic [W-1:0]               mst_data_q;
  logic [W-1:0]               mst_rdata_q;
  logic                       mst_wr_q;
  logic                       wait_q;
  logic [31:0]                rdata_q;
  logic [31:0]                rdata_d;
  logic                       acc;
  logic                       wr_acc;
  logic                       rd_acc;
  logic [1:0]                 grp;
  logic [1:0]                 slot;
  logic [31:0]                flags;
  ppa_pkg::ppa_mode_type      mode;
  ppa_pkg::ppa_csf_type       chip_select_function;
  logic [1:0]                 mux_sel;
  logic [1:0]                 inc_mode;
  logic                       slave_mode;
  logic                       busy;
  logic                       start_rd;
  logic                       start_wr;
  logic                       cs_role;
  logic                       host_wr;
  logic                       host_rd;
  logic [1:0]                 host_idx;
  logic [W-1:0]               in_data [ppa_pkg::NUM_SLOTS];
  logic [ppa_pkg::NUM_SLOTS-1:0] in_full;
  logic [ppa_pkg::NUM_SLOTS-1:0] out_empty;
  logic [ppa_pkg::NUM_SLOTS-1:0] writable;
  logic [W-1:0]               host_dout;
  logic                       in_ovr;
  logic                       out_unr;
  logic [ppa_pkg::ADDR_LO_W-1:0] addr_lo;
  logic [ppa_pkg::ADDR_LO_W:0]   addr_step;
  logic                       addr_hi;

  ppa_cycle_if cyc ();

  // byte-lane merge used for the control, target and pin registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  // hold phase length for a cycle of the given direction
  function automatic logic [ppa_pkg::CNT_W-1:0] hold_len(input logic [1:0] code,
                                                        input logic is_wr,
                                                        input logic [3:0] width);
    logic [ppa_pkg::CNT_W-1:0] r;
    r = {3'h0, code};
    if (width == ppa_pkg::WIDTH_NONE) begin
      r = is_wr ? ppa_pkg::ONE_CYCLE : ppa_pkg::NO_CYCLE;
    end else if (is_wr) begin
      r = r + ppa_pkg::ONE_CYCLE;
    end
    return r;
  endfunction

  assign mode       = ppa_pkg::ppa_mode_type'(ctrl_q[ppa_pkg::CTRL_MODE_LSB +: 2]);
  assign chip_select_function        = ppa_pkg::ppa_csf_type'(ctrl_q[ppa_pkg::CTRL_CSF_LSB +: 2]);
  assign mux_sel    = ctrl_q[ppa_pkg::CTRL_MUX_LSB +: 2];
  assign inc_mode   = ctrl_q[ppa_pkg::CTRL_INC_LSB +: 2];
  assign slave_mode = (mode == ppa_pkg::MODE_LEGACY) || (mode == ppa_pkg::MODE_ADDR_SLAVE);
  assign cs_role    = (chip_select_function == ppa_pkg::CSF_CHIPSEL);
  assign busy       = (cyc.phase != ppa_pkg::PH_IDLE);

  assign acc    = (AVS_READ || AVS_WRITE) && !wait_q;
  assign wr_acc = AVS_WRITE && !wait_q;
  assign rd_acc = AVS_READ && !wait_q;
  assign grp    = AVS_ADDRESS[5:4];
  assign slot   = AVS_ADDRESS[3:2];

  // legacy slave only uses slot 0
  assign host_idx = (mode == ppa_pkg::MODE_ADDR_SLAVE) ? HOST_ADDR : 2'h0;
  assign host_wr  = slave_mode && HOST_CS && HOST_WR;
  assign host_rd  = slave_mode && HOST_CS && HOST_RD;
  assign writable = (mode == ppa_pkg::MODE_ADDR_SLAVE) ? 4'hF : 4'h1;

  always_comb begin
    flags = '0;
    if (slave_mode) begin
      flags[ppa_pkg::FLG_IN_ALL]  = &(in_full | ~writable);
      flags[ppa_pkg::FLG_IN_OVR]  = in_ovr;
      flags[ppa_pkg::FLG_IN_LSB +: ppa_pkg::NUM_SLOTS]  = in_full;
      flags[ppa_pkg::FLG_OUT_ALL] = &(out_empty | ~writable);
      flags[ppa_pkg::FLG_OUT_UNR] = out_unr;
      flags[ppa_pkg::FLG_OUT_LSB +: ppa_pkg::NUM_SLOTS] = out_empty;
    end
  end

  always_comb begin
    rdata_d = '0;
    if (grp == ppa_pkg::GRP_IN) begin
      rdata_d[W-1:0] = in_data[slot];
    end else begin
      case (AVS_ADDRESS)
        ppa_pkg::OFS_CTRL: begin
          rdata_d = ctrl_q;
          rdata_d[ppa_pkg::CTRL_BUSY_BIT] = busy;
        end
        ppa_pkg::OFS_TARGET: rdata_d = target_q;
        ppa_pkg::OFS_PINS:   rdata_d = pins_q;
        ppa_pkg::OFS_FLAGS:  rdata_d = flags;
        ppa_pkg::OFS_MASTER: begin
          rdata_d[W-1:0] = mst_rdata_q;
          rdata_d[ppa_pkg::CTRL_BUSY_BIT] = busy;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  // one wait cycle per access; the answer stands when waitrequest drops
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
      wait_q  <= 1'b0;
      rdata_q <= rdata_d;
    end else begin
      wait_q  <= 1'b1;
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA    = rdata_q;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_q <= ppa_pkg::CTRL_RESET;
      pins_q <= ppa_pkg::PINS_RESET;
    end else if (wr_acc) begin
      if (AVS_ADDRESS == ppa_pkg::OFS_CTRL) begin
        ctrl_q <= merge(ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE, ppa_pkg::CTRL_MASK);
      end
      if (AVS_ADDRESS == ppa_pkg::OFS_PINS) begin
        pins_q <= merge(pins_q, AVS_WRITEDATA, AVS_BYTEENABLE, ppa_pkg::PINS_MASK);
      end
    end
  end

  // master command: start only when idle; a request while busy is dropped
  assign start_rd = wr_acc && (AVS_ADDRESS == ppa_pkg::OFS_MASTER) && !slave_mode && !busy
                    && AVS_WRITEDATA[ppa_pkg::MST_RD_BIT];
  assign start_wr = wr_acc && (AVS_ADDRESS == ppa_pkg::OFS_MASTER) && !slave_mode && !busy
                    && AVS_WRITEDATA[ppa_pkg::MST_WR_BIT] && !AVS_WRITEDATA[ppa_pkg::MST_RD_BIT];

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mst_wr_q   <= 1'b0;
      mst_data_q <= '0;
    end else if (start_rd || start_wr) begin
      mst_wr_q   <= start_wr;
      mst_data_q <= AVS_WRITEDATA[ppa_pkg::MST_DATA_LSB +: W];
    end
  end

  assign cyc.start     = start_rd || start_wr;
  assign cyc.is_write  = start_wr;
  assign cyc.setup_cnt = (ctrl_q[ppa_pkg::CTRL_WIDTH_LSB +: 4] == ppa_pkg::WIDTH_NONE)
                         ? ppa_pkg::ONE_CYCLE
                         : {3'h0, ctrl_q[ppa_pkg::CTRL_SETUP_LSB +: 2]} + ppa_pkg::ONE_CYCLE;
  assign cyc.width_cnt = {1'b0, ctrl_q[ppa_pkg::CTRL_WIDTH_LSB +: 4]} + ppa_pkg::ONE_CYCLE;
  assign cyc.hold_cnt  = hold_len(ctrl_q[ppa_pkg::CTRL_HOLD_LSB +: 2], mst_wr_q || start_wr,
                                  ctrl_q[ppa_pkg::CTRL_WIDTH_LSB +: 4]);

  ppa_strobe_timer u_timer (
    .clk (CORE_CLK),
    .rst (RST),
    .cyc (cyc.timer)
  );

  // read data is taken on every strobe cycle; the last one counts
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mst_rdata_q <= '0;
    end else if (!mst_wr_q && (cyc.phase == ppa_pkg::PH_STROBE)) begin
      mst_rdata_q <= DATA_IN;
    end
  end

  assign addr_lo   = target_q[ppa_pkg::ADDR_LO_W-1:0];
  assign addr_hi   = target_q[ppa_pkg::ADDR_HI_BIT];
  assign addr_step = (inc_mode == ppa_pkg::INC_DOWN)
                     ? {1'b0, addr_lo} - {{ppa_pkg::ADDR_LO_W{1'b0}}, 1'b1}
                     : {1'b0, addr_lo} + {{ppa_pkg::ADDR_LO_W{1'b0}}, 1'b1};

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      target_q <= ppa_pkg::TARGET_RESET;
    end else if (wr_acc && (AVS_ADDRESS == ppa_pkg::OFS_TARGET)) begin
      target_q <= merge(target_q, AVS_WRITEDATA, AVS_BYTEENABLE, ppa_pkg::TARGET_MASK);
    end else if (cyc.done && ((inc_mode == ppa_pkg::INC_UP) ||
                              (inc_mode == ppa_pkg::INC_DOWN))) begin
      target_q[ppa_pkg::ADDR_LO_W-1:0] <= addr_step[ppa_pkg::ADDR_LO_W-1:0];
      if (!cs_role) begin
        target_q[ppa_pkg::ADDR_HI_BIT] <= addr_hi ^ addr_step[ppa_pkg::ADDR_LO_W];
      end
    end
  end

  ppa_slave_bufs u_bufs (
    .clk        (CORE_CLK),
    .rst        (RST),
    .host_wr    (host_wr),
    .host_rd    (host_rd),
    .host_idx   (host_idx),
    .host_din   (DATA_IN),
    .sw_rd_in   (rd_acc && (grp == ppa_pkg::GRP_IN)),
    .sw_wr_out  (wr_acc && (grp == ppa_pkg::GRP_OUT) && AVS_BYTEENABLE[0]),
    .sw_idx     (slot),
    .sw_din     (AVS_WRITEDATA[W-1:0]),
    .sw_flag_wr (wr_acc && (AVS_ADDRESS == ppa_pkg::OFS_FLAGS) && AVS_BYTEENABLE[1]
                 && AVS_BYTEENABLE[0]),
    .sw_ovr_bit (AVS_WRITEDATA[ppa_pkg::FLG_IN_OVR]),
    .sw_unr_bit (AVS_WRITEDATA[ppa_pkg::FLG_OUT_UNR]),
    .in_data    (in_data),
    .in_full    (in_full),
    .out_empty  (out_empty),
    .host_dout  (host_dout),
    .in_ovr     (in_ovr),
    .out_unr    (out_unr)
  );

  // data pins: host read answer in slave modes, write data in master modes
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      DATA_OUT <= '0;
      DATA_OE  <= 1'b0;
    end else if (slave_mode) begin
      DATA_OUT <= host_dout;
      DATA_OE  <= host_rd;
    end else begin
      DATA_OUT <= mst_data_q;
      DATA_OE  <= mst_wr_q && busy;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RD_STROBE <= 1'b0;
      WR_STROBE <= 1'b0;
    end else if (mode == ppa_pkg::MODE_MASTER_SEP) begin
      RD_STROBE <= !mst_wr_q && (cyc.phase == ppa_pkg::PH_STROBE);
      WR_STROBE <= mst_wr_q && (cyc.phase == ppa_pkg::PH_STROBE);
    end else if (mode == ppa_pkg::MODE_MASTER_ENB) begin
      // direction on the read pad, enable on the write pad
      RD_STROBE <= busy && !mst_wr_q;
      WR_STROBE <= (cyc.phase == ppa_pkg::PH_STROBE);
    end else begin
      RD_STROBE <= 1'b0;
      WR_STROBE <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PAD_OWN <= '0;
    end else begin
      PAD_OWN <= pins_q[14:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PAD_OUT <= '0;
    end else begin
      PAD_OUT <= target_q[14:0];
      // reserved function drives pad 14 low
      PAD_OUT[ppa_pkg::ADDR_HI_BIT] <= (chip_select_function == ppa_pkg::CSF_RSVD) ? 1'b0
                                       : cs_role ? (addr_hi && (slave_mode || busy))
                                       : addr_hi;
      if (mux_sel != ppa_pkg::MUX_SEPARATE) begin
        // latch strobes during the address phase
        PAD_OUT[1] <= (cyc.phase == ppa_pkg::PH_SETUP);
        PAD_OUT[0] <= (cyc.phase == ppa_pkg::PH_SETUP);
      end
    end
  end
endmodule

// >>> hdl/ppa_pkg.sv
/*
 Parallel port address/status block: register map, field positions,
 reset values and enumerations shared by every design file.
 Assumes a 32-bit word register bus and a single core clock.
*/
package ppa_pkg;

  localparam int BYTE_W    = 8;
  localparam int NUM_SLOTS = 4;
  localparam int ADDR_LO_W = 11;
  localparam int CNT_W     = 5;

  // register byte offsets
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_TARGET = 6'h04;
  localparam logic [5:0] OFS_PINS   = 6'h08;
  localparam logic [5:0] OFS_FLAGS  = 6'h0C;
  localparam logic [5:0] OFS_MASTER = 6'h30;
  // address[5:4] groups: slot index in address[3:2]
  localparam logic [1:0] GRP_IN     = 2'h1;
  localparam logic [1:0] GRP_OUT    = 2'h2;

  // port_control_reg fields
  localparam int CTRL_HOLD_LSB  = 0;
  localparam int CTRL_WIDTH_LSB = 2;
  localparam int CTRL_SETUP_LSB = 6;
  localparam int CTRL_MODE_LSB  = 8;
  localparam int CTRL_CSF_LSB   = 10;
  localparam int CTRL_MUX_LSB   = 12;
  localparam int CTRL_INC_LSB   = 14;
  localparam int CTRL_BUSY_BIT  = 16;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_FFFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // port_target_location and port_pin_assignment
  localparam int ADDR_HI_BIT = 14;
  localparam logic [31:0] TARGET_MASK  = 32'h0000_47FF;
  localparam logic [31:0] TARGET_RESET = 32'h0000_0000;
  localparam logic [31:0] PINS_MASK    = 32'h0000_47FF;
  localparam logic [31:0] PINS_RESET   = 32'h0000_0000;

  // port_buffer_flags fields
  localparam int FLG_IN_ALL   = 15;
  localparam int FLG_IN_OVR   = 14;
  localparam int FLG_IN_LSB   = 8;
  localparam int FLG_OUT_ALL  = 7;
  localparam int FLG_OUT_UNR  = 6;
  localparam int FLG_OUT_LSB  = 0;

  // master command register fields
  localparam int MST_RD_BIT   = 0;
  localparam int MST_WR_BIT   = 1;
  localparam int MST_DATA_LSB = 8;

  localparam logic [3:0]       WIDTH_NONE = 4'h0;
  localparam logic [CNT_W-1:0] ONE_CYCLE  = 5'h01;
  localparam logic [CNT_W-1:0] NO_CYCLE   = 5'h00;

  typedef enum logic [1:0] {
    MODE_LEGACY     = 2'h0,
    MODE_ADDR_SLAVE = 2'h1,
    MODE_MASTER_SEP = 2'h2,
    MODE_MASTER_ENB = 2'h3
  } ppa_mode_type;

  typedef enum logic [1:0] {
    CSF_ADDR_A  = 2'h0,
    CSF_ADDR_B  = 2'h1,
    CSF_CHIPSEL = 2'h2,
    CSF_RSVD    = 2'h3
  } ppa_csf_type;

  localparam logic [1:0] MUX_SEPARATE = 2'h0;
  localparam logic [1:0] INC_UP       = 2'h1;
  localparam logic [1:0] INC_DOWN     = 2'h2;

  // gray along idle -> setup -> strobe -> hold
  typedef enum logic [1:0] {
    PH_IDLE   = 2'h0,
    PH_SETUP  = 2'h1,
    PH_STROBE = 2'h3,
    PH_HOLD   = 2'h2
  } ppa_phase_type;

endpackage

// >>> hdl/ppa_cycle_if.sv
/*
 Carrier between the port controller and its strobe timer.
 Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
interface ppa_cycle_if;
  logic                        start;
  logic                        is_write;
  logic [ppa_pkg::CNT_W-1:0]   setup_cnt;
  logic [ppa_pkg::CNT_W-1:0]   width_cnt;
  logic [ppa_pkg::CNT_W-1:0]   hold_cnt;
  ppa_pkg::ppa_phase_type      phase;
  logic                        done;

  modport ctrl  (output start, is_write, setup_cnt, width_cnt, hold_cnt,
                 input  phase, done);
  modport timer (input  start, is_write, setup_cnt, width_cnt, hold_cnt,
                 output phase, done);
endinterface

// >>> hdl/ppa_strobe_timer.sv
/*
 Master cycle sequencer: setup, strobe and hold phases of given lengths.
 Assumes setup and width counts of at least one; a hold of zero skips it.
*/
`timescale 1ns/1ps
module ppa_strobe_timer (
  input  wire logic    clk,
  input  wire logic    rst,
  ppa_cycle_if.timer   cyc
);
  ppa_pkg::ppa_phase_type        phase_q;
  logic [ppa_pkg::CNT_W-1:0]     cnt_q;
  logic                          done_q;
  logic                          last;

  assign last      = (cnt_q == ppa_pkg::ONE_CYCLE);
  assign cyc.phase = phase_q;
  assign cyc.done  = done_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= ppa_pkg::PH_IDLE;
      cnt_q   <= ppa_pkg::NO_CYCLE;
    end else begin
      case (phase_q)
        ppa_pkg::PH_IDLE: begin
          if (cyc.start) begin
            phase_q <= ppa_pkg::PH_SETUP;
            cnt_q   <= cyc.setup_cnt;
          end
        end
        ppa_pkg::PH_SETUP: begin
          if (last) begin
            phase_q <= ppa_pkg::PH_STROBE;
            cnt_q   <= cyc.width_cnt;
          end else begin
            cnt_q <= cnt_q - ppa_pkg::ONE_CYCLE;
          end
        end
        ppa_pkg::PH_STROBE: begin
          if (last) begin
            // zero hold: read cycles end right after the strobe
            phase_q <= (cyc.hold_cnt == ppa_pkg::NO_CYCLE) ? ppa_pkg::PH_IDLE
                                                           : ppa_pkg::PH_HOLD;
            cnt_q   <= cyc.hold_cnt;
          end else begin
            cnt_q <= cnt_q - ppa_pkg::ONE_CYCLE;
          end
        end
        ppa_pkg::PH_HOLD: begin
          if (last) begin
            phase_q <= ppa_pkg::PH_IDLE;
          end else begin
            cnt_q <= cnt_q - ppa_pkg::ONE_CYCLE;
          end
        end
        default: begin
          phase_q <= ppa_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= last && ((phase_q == ppa_pkg::PH_HOLD) ||
                ((phase_q == ppa_pkg::PH_STROBE) && (cyc.hold_cnt == ppa_pkg::NO_CYCLE)));
    end
  end
endmodule

// >>> hdl/ppa_slave_bufs.sv
/*
 Slave-mode byte buffers: four input slots filled by the host, four
 output slots filled by software, with their full/empty/error flags.
 Assumes one-cycle host strobes synchronous to the core clock.
*/
`timescale 1ns/1ps
module ppa_slave_bufs (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          host_wr,
  input  wire logic                          host_rd,
  input  wire logic [1:0]                    host_idx,
  input  wire logic [ppa_pkg::BYTE_W-1:0]    host_din,
  input  wire logic                          sw_rd_in,
  input  wire logic                          sw_wr_out,
  input  wire logic [1:0]                    sw_idx,
  input  wire logic [ppa_pkg::BYTE_W-1:0]    sw_din,
  input  wire logic                          sw_flag_wr,
  input  wire logic                          sw_ovr_bit,
  input  wire logic                          sw_unr_bit,
  output logic [ppa_pkg::BYTE_W-1:0]         in_data [ppa_pkg::NUM_SLOTS],
  output logic [ppa_pkg::NUM_SLOTS-1:0]      in_full,
  output logic [ppa_pkg::NUM_SLOTS-1:0]      out_empty,
  output logic [ppa_pkg::BYTE_W-1:0]         host_dout,
  output logic                               in_ovr,
  output logic                               out_unr
);
  logic [ppa_pkg::BYTE_W-1:0] out_q [ppa_pkg::NUM_SLOTS];
  logic                       ovr_set;
  logic                       unr_set;

  assign ovr_set   = host_wr && in_full[host_idx];
  assign unr_set   = host_rd && out_empty[host_idx];
  assign host_dout = out_q[host_idx];

  always_ff @(posedge clk) begin
    for (int i = 0; i < ppa_pkg::NUM_SLOTS; i++) begin
      if (rst) begin
        in_full[i] <= 1'b0;
        in_data[i] <= '0;
      end else if (host_wr && (host_idx == i[1:0]) && !in_full[i]) begin
        in_full[i] <= 1'b1;
        in_data[i] <= host_din;
      end else if (sw_rd_in && (sw_idx == i[1:0])) begin
        in_full[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < ppa_pkg::NUM_SLOTS; i++) begin
      if (rst) begin
        out_empty[i] <= 1'b1;
        out_q[i]     <= '0;
      end else if (host_rd && (host_idx == i[1:0]) && !out_empty[i]) begin
        out_empty[i] <= 1'b1;
      end else if (sw_wr_out && (sw_idx == i[1:0])) begin
        out_empty[i] <= 1'b0;
        out_q[i]     <= sw_din;
      end
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      in_ovr  <= 1'b0;
      out_unr <= 1'b0;
    end else begin
      in_ovr  <= ovr_set || (sw_flag_wr ? sw_ovr_bit : in_ovr);
      out_unr <= unr_set || (sw_flag_wr ? sw_unr_bit : out_unr);
    end
  end
endmodule

// >>> sim/ppa_port_chk.sv
/* checker for ppa_port: bus answer, host echo, pad ownership, strobes.
   assumes it is bound to ppa_port and that writes use all byte lanes */
`timescale 1ns/1ps
module ppa_port_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic [5:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        HOST_CS,
  input wire logic        HOST_RD,
  input wire logic        DATA_OE,
  input wire logic        RD_STROBE,
  input wire logic        WR_STROBE,
  input wire logic [14:0] PAD_OWN
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic pw;
  assign pw = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 6'h08;
  chk_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("bus request not answered");
  chk_one_low: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  chk_host_echo: assert property (HOST_CS && HOST_RD |=> DATA_OE)
    else $error("host read not answered");
  chk_pad_cause: assert property ($changed(PAD_OWN) |-> $past(pw) || $past(pw, 2))
    else $error("pad ownership changed without write");
  chk_pad_value: assert property (pw |-> ##2 PAD_OWN == {$past(AVS_WRITEDATA[14], 2),
    3'h0, $past(AVS_WRITEDATA[10:0], 2)}) else $error("pad ownership wrong");
  chk_wr_drive: assert property (WR_STROBE && !RD_STROBE |-> DATA_OE)
    else $error("write strobe without data");
  chk_rd_float: assert property (RD_STROBE |-> !DATA_OE)
    else $error("data driven in read");
  // enable-style reads keep the read pad high until the cycle ends; only a write leaves the read pad low
  chk_wr_hold: assert property ($fell(WR_STROBE) && !RD_STROBE && !$past(RD_STROBE)
    |-> DATA_OE) else $error("write data not held");
  cover property (pw);
  cover property ($fell(WR_STROBE));
  cover property (HOST_CS && HOST_RD);
endmodule
bind ppa_port ppa_port_chk chk (.CORE_CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_WAITREQUEST, .HOST_CS, .HOST_RD, .DATA_OE, .RD_STROBE,
  .WR_STROBE, .PAD_OWN);

// >>> sim/ppa_host_model.sv
/* external host: one-cycle slave strobes.
   assumes strobes synchronous to clk */
`timescale 1ns/1ps
module ppa_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] dout,
  output logic            cs,
  output logic            rd,
  output logic            wr,
  output logic [1:0]      addr,
  output logic [7:0]      din
);
  initial {cs, rd, wr, addr, din} = '0;
  task automatic put(input logic [1:0] a, input logic [7:0] d);
    {cs, wr, addr, din} <= {2'h3, a, d};
    @(posedge clk);
    {cs, wr, din} <= {2'h0, ~d};
    @(posedge clk);
  endtask
  task automatic get(output logic [7:0] d);
    {cs, rd, addr} <= 4'hC;
    @(posedge clk);
    {cs, rd} <= 2'h0;
    @(posedge clk);
    d = dout;
  endtask
endmodule

// >>> sim/tb_ppa_port.sv
/* bench for ppa_port: registers, slave buffers, master cycle lengths.
   assumes ppa_host_model plays the host */
`timescale 1ns/1ps
module tb_ppa_port;
  typedef struct packed {logic [5:0] a; logic [31:0] d; logic [31:0] e;} ppa_row_type;
  logic        CORE_CLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, HOST_CS, HOST_RD;
  logic        HOST_WR, DATA_OE, RD_STROBE, WR_STROBE;
  logic [5:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic [1:0]  HOST_ADDR;
  logic [7:0]  DATA_IN, DATA_OUT;
  logic [14:0] PAD_OUT, PAD_OWN;
  int          n_fail = 0, n_compared = 0, cyc = 0, cs_n = 0;
  ppa_row_type rows[4] = '{'{6'h04, 32'hFFFF_FFFF, 32'h47FF},
    '{6'h08, 32'hFFFF_FFFF, 32'h47FF}, '{6'h0C, 32'h0, 32'h8F}, '{6'h3C, 32'hFFFF_FFFF, 32'h0}};
  ppa_port dut (.*);
  ppa_host_model h (.clk(CORE_CLK), .dout(DATA_OUT), .cs(HOST_CS), .rd(HOST_RD),
    .wr(HOST_WR), .addr(HOST_ADDR), .din(DATA_IN));
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    cyc++;
    if (PAD_OUT[14] === 1'b1) cs_n++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    {AVS_WRITE, AVS_READ, AVS_ADDRESS, AVS_WRITEDATA} <= {w, !w, a, d};
    do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    {AVS_WRITE, AVS_READ} <= 2'h0;
    @(posedge CORE_CLK);
  endtask
  task automatic flags(input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    bus(0, 6'h0C, 32'h0, q);
    chk("flags", q & m, e);
  endtask
  task automatic run(input logic [31:0] c, input logic w, input int e);
    logic [31:0] q;
    bus(1, 6'h00, c, q);
    bus(1, 6'h30, {30'h0, w, !w}, q);
    // pad 14 cannot be high yet, so no count is lost to the edge race
    cs_n = 0;
    do bus(0, 6'h30, 32'h0, q); while (q[16] !== 1'b0);
    chk("cs_len", 32'(cs_n), 32'(e));
    if (!w) chk("rd_byte", 32'(q[7:0]), 32'(DATA_IN));
  endtask
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    logic [31:0] q;
    logic [7:0]  b;
    {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    AVS_BYTEENABLE = 4'hF;
    RST = 1'b1;
    repeat (16) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    chk("own_rst", 32'(PAD_OWN), 32'h0);
    foreach (rows[i]) begin
      bus(1, rows[i].a, rows[i].d, q);
      bus(0, rows[i].a, 32'h0, q);
      chk("reg", q, rows[i].e);
    end
    chk("own", 32'(PAD_OWN), 32'h47FF);
    $display("test registers done");
    h.put(2'h0, 8'hA5);
    h.put(2'h0, 8'h5A);
    flags(32'h418F, 32'h7FFF);
    bus(0, 6'h10, 32'h0, q);
    chk("slot0", q, 32'hA5);
    bus(1, 6'h0C, 32'h0, q);
    flags(32'h8F);
    h.get(b);
    flags(32'hCF);
    bus(1, 6'h20, 32'h3C, q);
    bus(1, 6'h0C, 32'h0, q);
    flags(32'h0E);
    h.get(b);
    chk("host_rd", 32'(b), 32'h3C);
    flags(32'h8F);
    bus(1, 6'h00, 32'h100, q);
    for (int i = 0; i < 4; i++) h.put(i[1:0], 8'h10);
    flags(32'h8F8F);
    bus(0, 6'h1C, 32'h0, q);
    flags(32'h078F);
    $display("test slave done");
    // first step carries out of bit 10: bit 14 must still not move
    bus(1, 6'h04, 32'h47FF, q);
    for (int i = 0; i < 4; i++) begin
      run(32'h4A04 | i, 1'b1, 4 + i);
      run(32'h4A04 | i, 1'b0, 3 + i);
    end
    run(32'h4AC3, 1'b1, 3);
    run(32'h4AC3, 1'b0, 2);
    run(32'h4B04, 1'b1, 4);
    run(32'h4B04, 1'b0, 3);
    bus(0, 6'h04, 32'h0, q);
    chk("cs_kept", q & 32'h7800, 32'h4000);
    flags(32'h0);
    $display("test master done");
    stop_test();
  end
endmodule
